// [hdl/xau_defines.svh]
// constants for the extended arithmetic sequencer
// Functional notes
// - decode both normalize forms, prepare as long left shift, flag normalization
// - multiply prep loads count from operand, sets sign and negate flops
// - divide leaves quotient in extension register, remainder in result register
// - signed divide needs carry clear; unit leaves it alone unless overflow
// - divide prep loads counter with two's complement of instruction count
// - divide prep performs one memory read placing divisor in operand register
// - divide treats quantities unsigned, ends when counter reaches zero
// - signed divide sets sign flop when result bit 00 is one
// - signed divide sets negate flop when carry differs from result bit 00
// - sign and negate flops complement registers in prep and fix at end
// - first divide step subtracts divisor from upper dividend, then shifts
// - later steps add when partial sign negative, subtract when positive
// - after each add or subtract shift quotient left one place, and remainder too on all but the last step
// - overflow when divisor not greater than upper dividend on first subtract
// - overflow sets carry and ends the divide at once
`ifndef XAU_DEFINES_SVH
`define XAU_DEFINES_SVH
`define XAU_W          18
`define XAU_SCW        6
`define XAU_RST_WORD   18'h00000
`define XAU_RST_SC     6'h00
`define XAU_SC_ONES    6'h3F
`define XAU_LEFT_JUSTIFY_INSTR_WORD  18'h34124
`define XAU_LEFT_JUSTIFY_SIGNED_INSTR_WORD 18'h36124
`define XAU_MUL_OP     12'hD59
`define XAU_SIGNED_PRODUCT_INSTR_OP    12'hD79
`define XAU_DIV_OP     12'hD03
`define XAU_SIGNED_QUOTIENT_INSTR_OP    12'hD23
`define XAU_OP_HI      17
`define XAU_OP_LO      6
`define XAU_SC_HI      5
`define XAU_SC_LO      0
`define XAU_BIT06      11
`define XAU_BIT08      9
`define XAU_MSB        17
`define XAU_NEXT_MSB   16
`endif

// [hdl/xau_pkg.sv]
// types for the extended arithmetic sequencer
package xau_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_LEFT_JUSTIFY_INSTR, OP_LEFT_JUSTIFY_SIGNED_INSTR, OP_MUL, OP_SIGNED_PRODUCT_INSTR, OP_DIV, OP_SIGNED_QUOTIENT_INSTR
  } xau_op_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PREP, ST_FETCH, ST_MUL, ST_DIV, ST_LEFT_JUSTIFY_INSTR, ST_FIX, ST_DONE
  } xau_state_type;
endpackage

// [hdl/xau_divstep.sv]
// one non-restoring divide step
`timescale 1ns/10ps
`default_nettype none
module xau_divstep #(
  parameter int W = 18
) (
  input  wire logic [W-1:0] ac_i,
  input  wire logic [W-1:0] mq_i,
  input  wire logic [W-1:0] mi_i,
  input  wire logic         temp_i,
  input  wire logic         last_i,
  output logic      [W-1:0] ac_o,
  output logic      [W-1:0] mq_o,
  output logic              temp_o
);
  logic [W:0] rem;
  logic [W:0] res;
  logic       qbit;

  always_comb begin
    rem = {temp_i, ac_i};
    if (temp_i) begin
      res = rem + {1'b0, mi_i};
    end else begin
      res = rem + {1'b1, ~mi_i} + {{W{1'b0}}, 1'b1};
    end
    qbit   = ~res[W];
    temp_o = res[W];
    mq_o   = {mq_i[W-2:0], qbit};
    if (last_i) begin
      ac_o = res[W-1:0];
    end else begin
      ac_o = {res[W-2:0], mq_i[W-1]};
    end
  end
endmodule
`default_nettype wire

// [hdl/xau_seq.sv]
// normalize, multiply and divide sequencer of the extended arithmetic unit
`timescale 1ns/10ps
`default_nettype none
`include "xau_defines.svh"
module xau_seq #(
  parameter int W   = `XAU_W,
  parameter int SCW = `XAU_SCW
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          start_i,
  input  wire logic [W-1:0]  instr_i,
  input  wire logic [W-1:0]  ac_i,
  input  wire logic [W-1:0]  mq_i,
  input  wire logic          link_i,
  output logic               mem_rd_o,
  input  wire logic          mem_ack_i,
  input  wire logic [W-1:0]  mem_data_i,
  output logic [W-1:0]       ac_o,
  output logic [W-1:0]       mq_o,
  output logic               link_o,
  output logic [SCW-1:0]     sc_o,
  output logic               busy_o,
  output logic               done_o,
  output logic               left_justify_instr_flag_o,
  output logic               overflow_o,
  output xau_pkg::xau_op_type op_o
);
  import xau_pkg::*;

  // ==========================================================
  // decode
  function automatic xau_op_type decode(input logic [W-1:0] w);
    logic [11:0] top;
    top = w[`XAU_OP_HI:`XAU_OP_LO];
    if (w == `XAU_LEFT_JUSTIFY_INSTR_WORD) begin
      decode = OP_LEFT_JUSTIFY_INSTR;
    end else if (w == `XAU_LEFT_JUSTIFY_SIGNED_INSTR_WORD) begin
      decode = OP_LEFT_JUSTIFY_SIGNED_INSTR;
    end else if (top == `XAU_MUL_OP) begin
      decode = OP_MUL;
    end else if (top == `XAU_SIGNED_PRODUCT_INSTR_OP) begin
      decode = OP_SIGNED_PRODUCT_INSTR;
    end else if (top == `XAU_DIV_OP) begin
      decode = OP_DIV;
    end else if (top == `XAU_SIGNED_QUOTIENT_INSTR_OP) begin
      decode = OP_SIGNED_QUOTIENT_INSTR;
    end else begin
      decode = OP_NONE;
    end
  endfunction

  function automatic logic is_mul(input xau_op_type o);
    is_mul = (o == OP_MUL) || (o == OP_SIGNED_PRODUCT_INSTR);
  endfunction

  function automatic logic is_div(input xau_op_type o);
    is_div = (o == OP_DIV) || (o == OP_SIGNED_QUOTIENT_INSTR);
  endfunction

  // ==========================================================
  // state
  xau_state_type st, next_st;
  xau_op_type    op, next_op;
  logic [W-1:0]   ac, next_ac, mq, next_mq, mi, next_mi;
  logic [SCW-1:0] sc, next_sc;
  logic           link, next_link, sgn, next_sgn, neg, next_neg;
  logic           temp, next_temp, first, next_first;
  logic           nflag, next_nflag, ovf, next_ovf;
  logic           busy, next_busy, done, next_done, mem_rd, next_mem_rd;

  xau_op_type     in_op;
  logic [W:0]     mul_sum;
  logic           sc_last;
  logic           normalized;
  logic           div_ovf;
  logic [W-1:0]   ds_ac, ds_mq;
  logic           ds_temp;

  assign in_op      = decode(instr_i);
  assign sc_last    = (sc == `XAU_SC_ONES);
  assign mul_sum    = mq[0] ? ({1'b0, ac} + {1'b0, mi}) : {1'b0, ac};
  assign div_ovf    = first && (mi <= ac);
  assign normalized = (op == OP_LEFT_JUSTIFY_SIGNED_INSTR) ? (ac[`XAU_MSB] != ac[`XAU_NEXT_MSB]) : ac[`XAU_MSB];

  xau_divstep #(.W(W)) u_step (
    .ac_i   (ac),
    .mq_i   (mq),
    .mi_i   (mi),
    .temp_i (temp),
    .last_i (sc_last),
    .ac_o   (ds_ac),
    .mq_o   (ds_mq),
    .temp_o (ds_temp)
  );

  // ==========================================================
  // sequencing
  always_comb begin
    next_st     = st;
    next_op     = op;
    next_ac     = ac;
    next_mq     = mq;
    next_mi     = mi;
    next_sc     = sc;
    next_link   = link;
    next_sgn    = sgn;
    next_neg    = neg;
    next_temp   = temp;
    next_first  = first;
    next_nflag  = nflag;
    next_ovf    = ovf;
    next_busy   = busy;
    next_done   = 1'b0;
    next_mem_rd = mem_rd;
    case (st)
      ST_IDLE: begin
        if (start_i) begin
          next_op    = in_op;
          next_mi    = instr_i;
          next_ac    = ac_i;
          next_mq    = mq_i;
          next_link  = link_i;
          next_nflag = 1'b0;
          next_ovf   = 1'b0;
          next_temp  = 1'b0;
          next_busy  = 1'b1;
          next_sgn   = 1'b0;
          next_neg   = 1'b0;
          next_sc    = instr_i[`XAU_SC_HI:`XAU_SC_LO];
          next_st    = (in_op == OP_NONE) ? ST_DONE : ST_PREP;
          if (is_mul(in_op)) begin
            next_sgn = instr_i[`XAU_BIT06] & ac_i[`XAU_MSB];
            next_neg = instr_i[`XAU_BIT06] & (link_i != ac_i[`XAU_MSB]);
          end
          if (is_div(in_op)) begin
            next_sc = ~instr_i[`XAU_SC_HI:`XAU_SC_LO] + `XAU_SC_ONES + 6'h02;
          end
          if (in_op == OP_SIGNED_QUOTIENT_INSTR) begin
            next_sgn = ac_i[`XAU_MSB];
            next_neg = link_i != ac_i[`XAU_MSB];
          end
        end
      end
      ST_PREP: begin
        if (is_mul(op)) begin
          next_mq     = sgn ? ~ac : ac;
          next_ac     = mi[`XAU_BIT08] ? `XAU_RST_WORD : ac;
          next_mem_rd = 1'b1;
          next_st     = ST_FETCH;
        end else if (is_div(op)) begin
          if (sgn) begin
            next_ac = ~ac;
            next_mq = ~mq;
          end
          next_mem_rd = 1'b1;
          next_st     = ST_FETCH;
        end else begin
          next_sc = sc + 6'h01;
          next_st = ST_LEFT_JUSTIFY_INSTR;
        end
      end
      ST_FETCH: begin
        if (mem_ack_i) begin
          next_mi     = mem_data_i;
          next_mem_rd = 1'b0;
          next_first  = 1'b1;
          next_st     = is_mul(op) ? ST_MUL : ST_DIV;
        end
      end
      ST_MUL: begin
        next_ac = mul_sum[W:1];
        next_mq = {mul_sum[0], mq[W-1:1]};
        next_sc = sc + 6'h01;
        if (sc_last) begin
          next_st = ST_FIX;
        end
      end
      ST_DIV: begin
        next_first = 1'b0;
        if (div_ovf) begin
          next_link = 1'b1;
          next_ovf  = 1'b1;
          next_st   = ST_DONE;
        end else begin
          next_ac   = ds_ac;
          next_mq   = ds_mq;
          next_temp = ds_temp;
          next_sc   = sc + 6'h01;
          if (sc_last) begin
            next_st = ST_FIX;
          end
        end
      end
      ST_LEFT_JUSTIFY_INSTR: begin
        if (normalized) begin
          next_nflag = 1'b1;
          next_st    = ST_DONE;
        end else if (sc_last) begin
          next_st = ST_DONE;
        end else begin
          next_ac = {ac[W-2:0], mq[W-1]};
          next_mq = {mq[W-2:0], link};
          next_sc = sc + 6'h01;
        end
      end
      ST_FIX: begin
        if (is_mul(op)) begin
          next_mq = neg ? ~mq : mq;
        end else begin
          next_mq = neg ? ~mq : mq;
          if (temp) begin
            next_ac = sgn ? ~(ac + mi) : (ac + mi);
          end else begin
            next_ac = sgn ? ~ac : ac;
          end
        end
        next_st = ST_DONE;
      end
      ST_DONE: begin
        next_done = 1'b1;
        next_busy = 1'b0;
        next_st   = ST_IDLE;
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st     <= ST_IDLE;
      op     <= OP_NONE;
      ac     <= `XAU_RST_WORD;
      mq     <= `XAU_RST_WORD;
      mi     <= `XAU_RST_WORD;
      sc     <= `XAU_RST_SC;
      link   <= 1'b0;
      sgn    <= 1'b0;
      neg    <= 1'b0;
      temp   <= 1'b0;
      first  <= 1'b0;
      nflag  <= 1'b0;
      ovf    <= 1'b0;
      busy   <= 1'b0;
      done   <= 1'b0;
      mem_rd <= 1'b0;
    end else begin
      st     <= next_st;
      op     <= next_op;
      ac     <= next_ac;
      mq     <= next_mq;
      mi     <= next_mi;
      sc     <= next_sc;
      link   <= next_link;
      sgn    <= next_sgn;
      neg    <= next_neg;
      temp   <= next_temp;
      first  <= next_first;
      nflag  <= next_nflag;
      ovf    <= next_ovf;
      busy   <= next_busy;
      done   <= next_done;
      mem_rd <= next_mem_rd;
    end
  end

  assign ac_o        = ac;
  assign mq_o        = mq;
  assign link_o      = link;
  assign sc_o        = sc;
  assign busy_o      = busy;
  assign done_o      = done;
  assign left_justify_instr_flag_o = nflag;
  assign overflow_o  = ovf;
  assign mem_rd_o    = mem_rd;
  assign op_o        = op;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_left_justify_instr_flag_set: assert property (
    (st == ST_LEFT_JUSTIFY_INSTR && normalized) |=> nflag ##1 done)
    else $error("normalize flag or completion missing");
  chk_mul_count_load: assert property (
    (st == ST_IDLE && start_i && is_mul(in_op)) |=> sc == $past(instr_i[5:0]))
    else $error("multiply count not loaded from operand");
  chk_mul_sign_flops: assert property (
    (st == ST_IDLE && start_i && is_mul(in_op)) |=>
      (sgn == $past(instr_i[11] & ac_i[17])) && (neg == $past(instr_i[11] & (link_i ^ ac_i[17]))))
    else $error("multiply sign flops wrong");
  chk_mul_noadd_shift: assert property (
    (st == ST_MUL && !mq[0]) |=> ac == ($past(ac) >> 1))
    else $error("multiply shift without add wrong");
  chk_mul_end_comp: assert property (
    (st == ST_FIX && is_mul(op) && neg) |=> mq == ~$past(mq))
    else $error("product extension not complemented");
  chk_div_link_hold: assert property (
    (st == ST_DIV && !div_ovf) |=> $stable(link))
    else $error("carry changed during divide");
  chk_div_count_load: assert property (
    (st == ST_IDLE && start_i && is_div(in_op)) |=> sc == 6'(-$past(instr_i[5:0])))
    else $error("divide count not negated");
  chk_div_prep_comp: assert property (
    (st == ST_PREP && is_div(op) && sgn) |=> (ac == ~$past(ac)) && (mq == ~$past(mq)))
    else $error("divide prep complement missing");
  chk_div_overflow: assert property (
    (st == ST_DIV && first && mi <= ac) |=> link && ovf ##1 done)
    else $error("divide overflow not handled");
  chk_div_shift_left: assert property (
    (st == ST_DIV && !div_ovf && !sc_last) |=> mq[W-1:1] == $past(mq[W-2:0]))
    else $error("divide shift wrong");

  cov_mul_done: cover property ((st == ST_FIX && is_mul(op)) ##1 done);
  cov_div_ovf:  cover property (st == ST_DIV && div_ovf);
  cov_div_done: cover property ((st == ST_FIX && is_div(op)) ##1 done);
  cov_left_justify_instr_hit: cover property (st == ST_LEFT_JUSTIFY_INSTR && normalized);
endmodule
`default_nettype wire

// [sim/xau_mem_model.sv]
// memory model that answers the sequencer's operand fetch
`timescale 1ns/10ps
`default_nettype none
module xau_mem_model (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        mem_rd_i,
  input  wire logic [17:0] word_i,
  input  wire logic [3:0]  delay_i,
  output logic             mem_ack_o,
  output logic [17:0]      mem_data_o
);
  logic [3:0] wait_cnt;
  // the word is valid only with the answer; the inverse shows otherwise
  assign mem_data_o = mem_ack_o ? word_i : ~word_i;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_ack_o <= 1'b0;
      wait_cnt  <= 4'h0;
    end else begin
      mem_ack_o <= 1'b0;
      if (mem_rd_i && !mem_ack_o) begin
        if (wait_cnt == delay_i) begin
          mem_ack_o <= 1'b1;
          wait_cnt  <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/test_eae_left_justify_instr_mul_div_sequencer.sv]
// self-checking bench for the extended arithmetic sequencer
`timescale 1ns/10ps
`default_nettype none
`include "xau_defines.svh"
module test_eae_left_justify_instr_mul_div_sequencer;
  import xau_pkg::*;
  logic        clk_i;
  logic        resetn_i;
  logic        start_i;
  logic [17:0] instr_i;
  logic [17:0] ac_i;
  logic [17:0] mq_i;
  logic        link_i;
  logic        mem_rd_o;
  logic        mem_ack_i;
  logic [17:0] mem_data_i;
  logic [17:0] ac_o;
  logic [17:0] mq_o;
  logic        link_o;
  logic [5:0]  sc_o;
  logic        busy_o;
  logic        done_o;
  logic        left_justify_instr_flag_o;
  logic        overflow_o;
  xau_op_type  op_o;
  logic [17:0] mem_word;
  logic [3:0]  mem_delay;
  logic [5:0]  first_sc;
  int          mem_reads;
  int          ack_cyc;
  int          done_cyc;
  int          cycles;
  int          err_total;
  int          num_checks;

  xau_seq u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i), .instr_i(instr_i),
    .ac_i(ac_i), .mq_i(mq_i), .link_i(link_i), .mem_rd_o(mem_rd_o), .mem_ack_i(mem_ack_i),
    .mem_data_i(mem_data_i), .ac_o(ac_o), .mq_o(mq_o), .link_o(link_o), .sc_o(sc_o),
    .busy_o(busy_o), .done_o(done_o), .left_justify_instr_flag_o(left_justify_instr_flag_o), .overflow_o(overflow_o),
    .op_o(op_o));
  xau_mem_model u_mem (.clk_i(clk_i), .resetn_i(resetn_i), .mem_rd_i(mem_rd_o), .word_i(mem_word),
    .delay_i(mem_delay), .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // cycle count, operand fetch count and hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (mem_ack_i === 1'b1) begin
      mem_reads++;
      ack_cyc = cycles;
    end
    if (cycles == 5000) begin
      err_total++;
      $display("[FAIL] %0t run too long", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [17:0] ins, input logic [17:0] ac, input logic [17:0] mq,
                     input logic lk, input logic [17:0] word, input logic [3:0] dly);
    int n;
    @(posedge clk_i);
    #1;
    mem_reads = 0;
    mem_word  = word;
    mem_delay = dly;
    instr_i   = ins;
    ac_i      = ac;
    mq_i      = mq;
    link_i    = lk;
    start_i   = 1'b1;
    @(posedge clk_i);
    #1;
    start_i  = 1'b0;
    first_sc = sc_o;
    chk({17'h0, busy_o}, 18'h00001);
    n = 0;
    while (done_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    done_cyc = cycles;
    chk({17'h0, done_o}, 18'h00001);
    chk({17'h0, busy_o}, 18'h00000);
  endtask

  task automatic div_case(input logic [11:0] op, input logic [17:0] ac, input logic [17:0] mq,
                          input logic lk, input logic [17:0] d, input logic [3:0] dly,
                          input logic [17:0] eq, input logic [17:0] er);
    run({op, 6'h13}, ac, mq, lk, d, dly);
    chk({12'h000, first_sc}, 18'h0002D);
    chk(mq_o, eq);
    chk(ac_o, er);
    chk({17'h0, link_o}, {17'h0, lk});
    chk(18'(op_o), (op == `XAU_SIGNED_QUOTIENT_INSTR_OP) ? 18'(OP_SIGNED_QUOTIENT_INSTR) : 18'(OP_DIV));
    chk({17'h0, overflow_o}, 18'h00000);
    chk({12'h000, sc_o}, 18'h00000);
    chk(18'(mem_reads), 18'h00001);
  endtask

  task automatic divide_tests();
    div_case(`XAU_DIV_OP, 18'h00000, 18'h0000A, 1'b0, 18'h00005, 4'h0, 18'h00002, 18'h00000);
    div_case(`XAU_DIV_OP, 18'h00001, 18'h00007, 1'b0, 18'h003E8, 4'h7, 18'h00106, 18'h00097);
    div_case(`XAU_SIGNED_QUOTIENT_INSTR_OP, 18'h00000, 18'h0000A, 1'b1, 18'h00005, 4'h2, 18'h3FFFD, 18'h00000);
    div_case(`XAU_SIGNED_QUOTIENT_INSTR_OP, 18'h3FFFF, 18'h3FFF4, 1'b0, 18'h00005, 4'h1, 18'h3FFFD, 18'h3FFFE);
  endtask

  task automatic overflow_test();
    run({`XAU_DIV_OP, 6'h13}, 18'h00005, 18'h00000, 1'b0, 18'h00005, 4'h3);
    chk({17'h0, overflow_o}, 18'h00001);
    chk({17'h0, link_o}, 18'h00001);
    chk(18'(op_o), 18'(OP_DIV));
    chk(18'(done_cyc - ack_cyc), 18'h00002);
  endtask

  task automatic multiply_tests();
    run({`XAU_MUL_OP, 6'h2E}, 18'h3FFFF, 18'h00000, 1'b0, 18'h3FFFF, 4'h0);
    chk({12'h000, first_sc}, 18'h0002E);
    chk(ac_o, 18'h3FFFE);
    chk(mq_o, 18'h00001);
    chk(18'(op_o), 18'(OP_MUL));
    run({`XAU_SIGNED_PRODUCT_INSTR_OP, 6'h2E}, 18'h3FFFC, 18'h00000, 1'b0, 18'h00005, 4'h5);
    chk(ac_o, 18'h00000);
    chk(mq_o, 18'h3FFF0);
    chk(18'(op_o), 18'(OP_SIGNED_PRODUCT_INSTR));
  endtask

  task automatic normalize_tests();
    run(`XAU_LEFT_JUSTIFY_INSTR_WORD, 18'h00001, 18'h20000, 1'b0, 18'h00000, 4'h0);
    chk(ac_o, 18'h30000);
    chk(mq_o, 18'h00000);
    chk({17'h0, left_justify_instr_flag_o}, 18'h00001);
    chk({12'h000, sc_o}, 18'h00036);
    chk(18'(op_o), 18'(OP_LEFT_JUSTIFY_INSTR));
    run(`XAU_LEFT_JUSTIFY_SIGNED_INSTR_WORD, 18'h00001, 18'h00000, 1'b1, 18'h00000, 4'h0);
    chk(ac_o, 18'h10000);
    chk(mq_o, 18'h0FFFF);
    chk({17'h0, left_justify_instr_flag_o}, 18'h00001);
    chk(18'(op_o), 18'(OP_LEFT_JUSTIFY_SIGNED_INSTR));
    run(`XAU_LEFT_JUSTIFY_INSTR_WORD, 18'h00000, 18'h00000, 1'b0, 18'h00000, 4'h0);
    chk({17'h0, left_justify_instr_flag_o}, 18'h00000);
    chk(18'(op_o), 18'(OP_LEFT_JUSTIFY_INSTR));
    // a word that is none of the three groups finishes without work
    run(18'h00000, 18'h00001, 18'h00000, 1'b0, 18'h00000, 4'h0);
    chk(18'(op_o), 18'(OP_NONE));
    chk({17'h0, left_justify_instr_flag_o}, 18'h00000);
    chk(18'(mem_reads), 18'h00000);
  endtask

  initial begin
    err_total  = 0;
    num_checks = 0;
    cycles     = 0;
    mem_reads  = 0;
    ack_cyc    = 0;
    done_cyc   = 0;
    resetn_i   = 1'b0;
    start_i    = 1'b0;
    instr_i    = 18'h00000;
    ac_i       = 18'h00000;
    mq_i       = 18'h00000;
    link_i     = 1'b0;
    mem_word   = 18'h00000;
    mem_delay  = 4'h0;
    first_sc   = 6'h00;
    repeat (4) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    divide_tests();
    overflow_test();
    multiply_tests();
    normalize_tests();
    finish_test();
  end
endmodule
`default_nettype wire
